// ---- pkg/crg_regs.vh ----
// Purpose: constants for the console and boot ROM glue logic
// Assumes: included by the glue logic and by its bench
// Notes:   address patterns cover bus lines 29..2; sequencer codes are 5 bit
`ifndef CRG_REGS_VH
`define CRG_REGS_VH

// upper address patterns, bus lines 29..13 (17 bits)
`define CRG_UP_CONSOLE_PAT  17'h10080
`define CRG_UP_STATUS_PAT   17'h100FF
// rom pattern, bus lines 29..20 (10 bits)
`define CRG_ROM_PAT         10'h202
// lower console pattern, bus lines 12..6 must all be low
`define CRG_LOW_CONSOLE_PAT 7'h00
// lower status pattern, bus lines 12..2 must all be high
`define CRG_LOW_STATUS_PAT  11'h7FF
// acknowledge vector pattern, bus lines 6..2
`define CRG_IACK_DAL_PAT    5'h14
// cycle status pattern, lines 4,2,1,0 in that order
`define CRG_IACK_CS_PAT     4'hB

// synchroniser reset: strobe, write and mask pins idle high
`define CRG_PIN_IDLE        34'h3C0000000

// sequencer state codes
`define CRG_ST_IDLE         5'h00
`define CRG_ST_WR1          5'h01
`define CRG_ST_WR2          5'h02
`define CRG_ST_WR3          5'h03
`define CRG_ST_WR4          5'h04
`define CRG_ST_WR5          5'h05
`define CRG_ST_FIN_WR       5'h06
`define CRG_ST_IO1          5'h07
`define CRG_ST_IO2          5'h08
`define CRG_ST_FIN_IO       5'h09
`define CRG_ST_ROM1         5'h0A
`define CRG_ST_ROM2         5'h0B
`define CRG_ST_ROM3         5'h0C
`define CRG_ST_ROM4         5'h0D
`define CRG_ST_ROM5         5'h0E
`define CRG_ST_ROM6         5'h0F
`define CRG_ST_RD1          5'h11
`define CRG_ST_RD2          5'h12
`define CRG_ST_RD3          5'h13
`define CRG_ST_RD4          5'h14
`define CRG_ST_FIN_RD       5'h15
`define CRG_ST_FUP1         5'h16
`define CRG_ST_FUP2         5'h17
`define CRG_ST_FUP3         5'h18
`define CRG_ST_FIN_ROM      5'h19

`endif

// ---- rtl/crg_glue.v ----
// Purpose: address decode, acknowledge decode and console/rom sequencer
// Assumes: all processor pins are asynchronous to i_clock, tick clock is
//          much slower than i_clock so its edges are seen as ticks
// Notes:   pins pass two flip-flops; strobe edges are detected on i_clock
`timescale 1ns/1ps
`include "crg_regs.vh"

module crg_glue
(
  input  wire        i_clock,
  input  wire        i_rst_b,
  input  wire        i_address_strobe_b,
  input  wire        i_data_strobe_b,
  input  wire        i_write_b,
  input  wire        i_low_byte_mask_b,
  input  wire [29:2] i_data_address_lines,
  input  wire [4:0]  i_cycle_status_lines,
  input  wire        i_primary_tick_clock,
  input  wire        i_late_half_flag,
  output reg         o_console_select,
  output reg         o_status_led_select,
  output reg         o_boot_rom_select,
  output reg         o_uart_data_enable,
  output reg         o_cycle_ready_out,
  output reg         o_vector_drive_enable
);

  // two-stage synchronisers for every pin
  reg  [33:0] sync1_q;
  reg  [33:0] sync2_q;
  wire [33:0] pins_raw;
  assign pins_raw = {i_address_strobe_b, i_data_strobe_b, i_write_b,
                     i_low_byte_mask_b, i_primary_tick_clock,
                     i_late_half_flag, i_data_address_lines};

  always @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      // idle levels, so no false strobe edge follows reset
      sync1_q <= `CRG_PIN_IDLE;
      sync2_q <= `CRG_PIN_IDLE;
    end
    else
    begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  // cycle status has its own pair to keep widths plain
  reg  [4:0]  cs1_q;
  reg  [4:0]  cs2_q;
  always @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cs1_q <= 5'h00;
      cs2_q <= 5'h00;
    end
    else
    begin
      cs1_q <= i_cycle_status_lines;
      cs2_q <= cs1_q;
    end
  end

  wire        as_b_s   = sync2_q[33];
  wire        ds_b_s   = sync2_q[32];
  wire        wr_b_s   = sync2_q[31];
  wire        bm0_b_s  = sync2_q[30];
  wire        tick_s   = sync2_q[29];
  wire        late_s   = sync2_q[28];
  wire [29:2] dal_s    = sync2_q[27:0];

  // edge detectors read only synchronised levels
  reg         as_b_prev_q;
  reg         tick_prev_q;
  always @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      as_b_prev_q <= 1'b1;
      tick_prev_q <= 1'b0;
    end
    else
    begin
      as_b_prev_q <= as_b_s;
      tick_prev_q <= tick_s;
    end
  end

  wire as_rise   = as_b_prev_q & ~as_b_s;  // strobe assertion
  wire tick_rise = tick_s & ~tick_prev_q;  // one sequencer step

  // decode terms on the synchronised bus
  wire up_con_d  = (dal_s[29:13] == `CRG_UP_CONSOLE_PAT);
  wire rom_d     = (dal_s[29:20] == `CRG_ROM_PAT);
  wire up_st_d   = (dal_s[29:13] == `CRG_UP_STATUS_PAT);
  wire low_con_d = (dal_s[12:6] == `CRG_LOW_CONSOLE_PAT);
  wire low_st_d  = (dal_s[12:2] == `CRG_LOW_STATUS_PAT);
  wire iack_d    = wr_b_s
                 & ({cs2_q[4], cs2_q[2], cs2_q[1], cs2_q[0]}
                    == `CRG_IACK_CS_PAT)
                 & (dal_s[6:2] == `CRG_IACK_DAL_PAT);

  // latched selects; set on strobe assertion wins over the clear
  reg up_con_q;
  reg rom_q;
  reg up_st_q;
  reg low_con_q;
  reg low_st_q;
  reg iack_q;
  reg store_q;
  reg bm0_q;

  // both clears fire once the strobe is released; a real async clear
  // from logic would glitch, so it acts on the next i_clock edge
  wire sel_clear  = as_b_s & (up_con_q | rom_q | up_st_q);
  wire iack_clear = as_b_s & (iack_q | low_con_q | low_st_q);

  always @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      up_con_q  <= 1'b0;
      rom_q     <= 1'b0;
      up_st_q   <= 1'b0;
      low_con_q <= 1'b0;
      low_st_q  <= 1'b0;
      iack_q    <= 1'b0;
      store_q   <= 1'b0;
      bm0_q     <= 1'b0;
    end
    else if (as_rise)
    begin
      up_con_q  <= up_con_d;
      rom_q     <= rom_d;
      up_st_q   <= up_st_d;
      low_con_q <= low_con_d;
      low_st_q  <= low_st_d;
      iack_q    <= iack_d;
      store_q   <= ~wr_b_s;
      bm0_q     <= ~bm0_b_s;
    end
    else
    begin
      if (sel_clear)
      begin
        up_con_q <= 1'b0;
        rom_q    <= 1'b0;
        up_st_q  <= 1'b0;
      end
      if (iack_clear)
      begin
        low_con_q <= 1'b0;
        low_st_q  <= 1'b0;
        iack_q    <= 1'b0;
      end
    end
  end

  wire console_sel = up_con_q & low_con_q;
  wire status_acc  = up_st_q & low_st_q;

  // select outputs and vector enable, all registered
  always @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_console_select      <= 1'b0;
      o_status_led_select   <= 1'b0;
      o_boot_rom_select     <= 1'b0;
      o_vector_drive_enable <= 1'b0;
    end
    else
    begin
      o_console_select      <= console_sel;
      o_status_led_select   <= status_acc;
      o_boot_rom_select     <= rom_q;
      o_vector_drive_enable <= iack_q & ~ds_b_s;
    end
  end

  // strobe as the sequencer sees it, sampled on tick edges
  reg sync_as_q;
  always @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      sync_as_q <= 1'b0;
    else if (tick_rise)
      sync_as_q <= ~as_b_s;
  end

  // qualified access terms
  wire wr_acc   = store_q & bm0_q & console_sel & sync_as_q;
  wire rd_acc   = ~store_q & bm0_q & console_sel & sync_as_q;
  wire rom_acc  = store_q & rom_q & sync_as_q;
  wire iack_acc = (iack_q | status_acc) & sync_as_q;

  // sequencer; late half flag low marks phase one or two
  reg  [4:0] state_q;
  reg  [4:0] state_d;
  reg        den_d;
  reg        rdy_d;

  always @*
  begin
    state_d = `CRG_ST_IDLE;
    den_d   = 1'b0;
    rdy_d   = 1'b0;
    case (state_q)
      `CRG_ST_IDLE:
      begin
        if (wr_acc)
        begin
          state_d = `CRG_ST_WR1;
          den_d   = 1'b1;
        end
        else if (rd_acc)
        begin
          state_d = `CRG_ST_RD1;
          den_d   = 1'b1;
        end
        else if (iack_acc)
          state_d = `CRG_ST_IO1;
        else if (rom_acc)
          state_d = `CRG_ST_ROM1;
      end
      `CRG_ST_WR1, `CRG_ST_WR2, `CRG_ST_WR3, `CRG_ST_WR4,
      `CRG_ST_RD1, `CRG_ST_RD2, `CRG_ST_RD3:
      begin
        state_d = state_q + 5'h01;
        den_d   = 1'b1;
      end
      `CRG_ST_WR5, `CRG_ST_RD4:
      begin
        den_d   = 1'b1;
        rdy_d   = ~late_s;
        state_d = late_s ? state_q : state_q + 5'h01;
      end
      `CRG_ST_FIN_WR, `CRG_ST_FIN_RD:
        state_d = `CRG_ST_FUP1;
      `CRG_ST_FUP1:
        state_d = `CRG_ST_FUP2;
      `CRG_ST_FUP2:
        state_d = `CRG_ST_FUP3;
      `CRG_ST_IO1:
        state_d = `CRG_ST_IO2;
      `CRG_ST_IO2:
      begin
        rdy_d   = ~late_s;
        state_d = late_s ? `CRG_ST_IO2 : `CRG_ST_FIN_IO;
      end
      // more rom states here would add wait states for slower parts
      `CRG_ST_ROM1, `CRG_ST_ROM2, `CRG_ST_ROM3, `CRG_ST_ROM4, `CRG_ST_ROM5:
        state_d = state_q + 5'h01;
      `CRG_ST_ROM6:
      begin
        rdy_d   = ~late_s;
        state_d = late_s ? `CRG_ST_ROM6 : `CRG_ST_FIN_ROM;
      end
      default:
        state_d = `CRG_ST_IDLE;
    endcase
  end

  always @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_q            <= `CRG_ST_IDLE;
      o_uart_data_enable <= 1'b0;
      o_cycle_ready_out  <= 1'b0;
    end
    else if (tick_rise)
    begin
      state_q            <= state_d;
      o_uart_data_enable <= den_d;
      o_cycle_ready_out  <= rdy_d;
    end
  end

endmodule

// ---- sim/crg_cpu_model.sv ----
// Purpose: processor side: free running tick clock and phase flag
// Assumes: a tick period of 8 system clocks
// Notes:   four ticks make one bus phase cycle
`timescale 1ns/1ps
module crg_cpu_model
(
  input  wire i_clock,
  input  wire i_rst_b,
  output wire o_tick,
  output wire o_late
);
  reg [4:0] cnt_q;
  // tick runs free, far slower than the 3 clock minimum spacing
  always @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      cnt_q <= 5'h00;
    else
      cnt_q <= cnt_q + 5'h01;
  end
  assign o_tick = cnt_q[2];
  assign o_late = cnt_q[4]; // high in phases three and four
endmodule

// ---- sim/crg_glue_properties.sv ----
// Purpose: port checks on the glue decoder and sequencer
// Assumes: tick clock period of 8 system clocks, from the cpu model
// Notes:   pins pass two sync flops, so delays below allow for that
`timescale 1ns/1ps
module crg_glue_properties
(
  input wire i_clock,
  input wire i_rst_b,
  input wire i_address_strobe_b,
  input wire i_data_strobe_b,
  input wire i_primary_tick_clock,
  input wire o_console_select,
  input wire o_status_led_select,
  input wire o_boot_rom_select,
  input wire o_uart_data_enable,
  input wire o_cycle_ready_out,
  input wire o_vector_drive_enable
);
  wire sel_any;
  wire out_any;
  // any select, any output
  assign sel_any = o_console_select | o_status_led_select | o_boot_rom_select;
  assign out_any = sel_any | o_uart_data_enable | o_cycle_ready_out
                 | o_vector_drive_enable;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // ready holds for exactly one tick period, then drops
  sequence s_ready_hold;
    o_cycle_ready_out [*8] ##1 !o_cycle_ready_out;
  endsequence
  // tick pin rise: two sync flops and the edge detect come first
  sequence s_tick_three_back;
    !$past(i_primary_tick_clock, 4) && $past(i_primary_tick_clock, 3);
  endsequence
  property p_step;
    $changed(o_cycle_ready_out) || $changed(o_uart_data_enable)
      |-> s_tick_three_back;
  endproperty
  a_step: assert property (p_step)
    else $error("sequencer output moved off a tick");
  property p_rst_out; $rose(i_rst_b) |-> !out_any; endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("output high right after reset");
  property p_excl;
    $onehot0({o_console_select, o_status_led_select, o_boot_rom_select});
  endproperty
  a_excl: assert property (p_excl)
    else $error("two selects at once");
  property p_sel_rise;
    $rose(sel_any) |-> !$past(i_address_strobe_b, 3) && !i_address_strobe_b;
  endproperty
  a_sel_rise: assert property (p_sel_rise)
    else $error("select rose without a strobe");
  property p_idle_clr; i_address_strobe_b [*6] |-> !sel_any; endproperty
  a_idle_clr: assert property (p_idle_clr)
    else $error("select kept after strobe release");
  property p_vec_ds; i_data_strobe_b [*4] |-> !o_vector_drive_enable;
  endproperty
  a_vec_ds: assert property (p_vec_ds)
    else $error("vector enable without data strobe");
  property p_ready_w; $rose(o_cycle_ready_out) |-> s_ready_hold; endproperty
  a_ready_w: assert property (p_ready_w)
    else $error("ready not exactly one tick long");
  property p_ready_en; $fell(o_cycle_ready_out) |-> !o_uart_data_enable;
  endproperty
  a_ready_en: assert property (p_ready_en)
    else $error("data enable outlived finish state");
  property p_en_sel; $rose(o_uart_data_enable) |-> o_console_select;
  endproperty
  a_en_sel: assert property (p_en_sel)
    else $error("data enable without console select");
  property p_gap;
    $rose(o_uart_data_enable) |-> !o_cycle_ready_out [*8];
  endproperty
  a_gap: assert property (p_gap)
    else $error("ready too soon after data enable");
endmodule
bind crg_glue crg_glue_properties chk_u (.i_clock, .i_rst_b,
  .i_address_strobe_b, .i_data_strobe_b, .i_primary_tick_clock,
  .o_console_select,
  .o_status_led_select, .o_boot_rom_select, .o_uart_data_enable,
  .o_cycle_ready_out, .o_vector_drive_enable);

// ---- sim/tb_console_rom_glue_logic.sv ----
// Purpose: self-checking bench for the glue logic
// Assumes: cpu model supplies tick and phase flag
// Notes:   each bus cycle waits for ready under a bound
`timescale 1ns/1ps
`include "crg_regs.vh"
`define CHK(nm, e, g) \
  begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_console_rom_glue_logic;
  reg         clk = 0;
  reg         rst_b = 0;
  reg         as_b = 1;
  reg         ds_b = 1;
  reg         wr_b = 1;
  reg         bm_b = 1;
  reg  [29:2] data_address_lines = 28'h0;
  reg  [4:0]  cs = 5'h00;
  wire        tick, late, csel, ssel, rsel, den, rdy, vec;
  integer     n_errors = 0;
  integer     checked = 0;
  integer     i;
  reg  [31:0] ra;
  // design under test and processor model
  crg_glue dut_u (.i_clock(clk), .i_rst_b(rst_b), .i_address_strobe_b(as_b),
    .i_data_strobe_b(ds_b), .i_write_b(wr_b), .i_low_byte_mask_b(bm_b),
    .i_data_address_lines(data_address_lines), .i_cycle_status_lines(cs),
    .i_primary_tick_clock(tick), .i_late_half_flag(late),
    .o_console_select(csel), .o_status_led_select(ssel),
    .o_boot_rom_select(rsel), .o_uart_data_enable(den),
    .o_cycle_ready_out(rdy), .o_vector_drive_enable(vec));
  crg_cpu_model cpu_u (.i_clock(clk), .i_rst_b(rst_b), .o_tick(tick),
    .o_late(late));
  always #5 clk = ~clk;
  // expected {console, status, rom} selects for a byte address
  function [2:0] exp_sel(input [31:0] a);
  begin
    exp_sel[2] = a[29:13] == `CRG_UP_CONSOLE_PAT && a[12:6] == 7'h00;
    exp_sel[1] = a[29:13] == `CRG_UP_STATUS_PAT && &a[12:2];
    exp_sel[0] = a[29:20] == `CRG_ROM_PAT;
  end
  endfunction
  // one bus cycle; ready, data enable and vector are watched from the select check until ready or the bound
  task cyc(input [31:0] a, input w, input m, input [4:0] c);
    reg [2:0] es;
    reg       ack, acc, got_r, got_v, got_e;
    integer   k;
  begin
    es = exp_sel(a);
    ack = w && c[4] && !c[2] && c[1] && c[0] && a[6:2] == 5'h14;
    acc = (es[2] && !m) || ack || es[1] || (es[0] && !w);
    @(posedge clk);
    data_address_lines <= a[29:2];
    wr_b <= w;
    bm_b <= m;
    cs <= c;
    @(posedge clk);
    as_b <= 1'b0;
    repeat (6) @(posedge clk);
    ds_b <= 1'b0;
    @(negedge clk);
    `CHK("selects", es, {csel, ssel, rsel})
    {got_r, got_v, got_e} = 3'h0;
    for (k = 0; k < 150 && !got_r; k++)
    begin
      @(negedge clk);
      got_r = rdy;
      got_v |= vec;
      got_e |= den;
    end
    `CHK("ready", acc, got_r)
    `CHK("data enable", es[2] && !m, got_e)
    `CHK("vector", ack, got_v)
    @(posedge clk);
    as_b <= 1'b1;
    ds_b <= 1'b1;
    repeat (40) @(posedge clk);
    @(negedge clk);
    `CHK("cleared", 4'h0, {csel, ssel, rsel, vec})
  end
  endtask
  task tally_and_finish;
  begin
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  // watchdog well past the expected run of about 4000 clocks
  initial
  begin
    #300000;
    n_errors++;
    tally_and_finish;
  end
  // corner cases first, then random addresses near the rom range
  initial
  begin
    i = $urandom(32'hC2E7);
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    cyc(32'h20100000, 0, 0, 5'h00);
    cyc(32'h2010003C, 1, 0, 5'h00);
    cyc(32'h2010003C, 1, 1, 5'h00);
    cyc(32'h20101000, 1, 0, 5'h00);
    cyc(32'h201FFFFC, 1, 0, 5'h00);
    cyc(32'h202FFFFC, 0, 0, 5'h00);
    cyc(32'h20200000, 1, 0, 5'h00);
    cyc(32'h20300000, 0, 0, 5'h00);
    cyc(32'h00000050, 1, 0, 5'h13);
    cyc(32'h00000050, 0, 0, 5'h13);
    for (i = 0; i < 8; i++)
    begin
      ra = ($urandom & 32'h003FFFFC) | 32'h20000000;
      cyc(ra, $urandom, $urandom, $urandom);
    end
    // cut a console write in mid-flight with a second reset
    @(posedge clk);
    data_address_lines <= 28'h8040000;
    wr_b <= 1'b0;
    bm_b <= 1'b0;
    @(posedge clk);
    as_b <= 1'b0;
    for (i = 0; i < 100 && !den; i++)
      @(negedge clk);
    `CHK("enable before reset", 1'b1, den)
    @(posedge clk);
    rst_b <= 1'b0;
    as_b <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK("in reset", 4'h0, {den, rdy, vec, csel})
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    cyc(32'h20100000, 0, 0, 5'h00);
    tally_and_finish;
  end
endmodule
